// file: sev_pkg.sv
`default_nettype none
// ----------------------------------------
// Event status constants
// ----------------------------------------
package sev_pkg;
    localparam logic [7:0] EnableReset     = 8'h00;
    localparam logic [7:0] LatchReset      = 8'h00;
    localparam int         BitCmdErr       = 5;
    localparam int         BitExeErr       = 4;
    localparam int         BitDevErr       = 3;
    localparam int         BitQryErr       = 2;
    localparam int         BitOpDone       = 0;
    localparam logic [7:0] UsedMask        = 8'h3D;
    localparam int         SummaryBit      = 5;
    localparam logic [2:0] ClassCmd        = 3'h1;
    localparam logic [2:0] ClassExe        = 3'h2;
    localparam logic [2:0] ClassDev        = 3'h3;
    localparam logic [2:0] ClassQry        = 3'h4;

    typedef enum logic [2:0] {
        OP_IDLE    = 3'b001,
        OP_WAIT    = 3'b010,
        OP_DONE    = 3'b100
    } sev_op_e;
endpackage
`default_nettype wire

// file: sev_error_class.sv
`default_nettype none
// ----------------------------------------
// Error code class decoder
// ----------------------------------------
module sev_error_class (
    // Error report
    input  wire logic       errValid,
    input  wire logic [2:0] errClass,
    // Decoded one-hot event bits
    output logic      [7:0] errEvents
);
    logic isCmd;
    logic isExe;
    logic isDev;
    logic isQry;

    // Class match for the reported error; unknown classes raise nothing
    assign isCmd = errValid && (errClass == sev_pkg::ClassCmd);
    assign isExe = errValid && (errClass == sev_pkg::ClassExe);
    assign isDev = errValid && (errClass == sev_pkg::ClassDev);
    assign isQry = errValid && (errClass == sev_pkg::ClassQry);

    // Place each match at its event bit; unused bits stay low
    assign errEvents = (8'(isCmd) << sev_pkg::BitCmdErr)
        | (8'(isExe) << sev_pkg::BitExeErr)
        | (8'(isDev) << sev_pkg::BitDevErr)
        | (8'(isQry) << sev_pkg::BitQryErr);
endmodule
`default_nettype wire

// file: sev_status_logic.sv
`default_nettype none
// Contract
// - Enable mask accepts 0..255, stored as eight bits, resets to 0.
// - Summary bit 5 is the OR of latched events gated by the mask.
// - Mask query returns the stored mask unchanged.
// - Event query returns the latch contents, then clears it; events set in that cycle stay.
// - Bits: command 5, execution 4, device 3, query 2, done 0; rest unused.
// - Any 1xx class error sets the command error bit.
// - Any 2xx class error sets the execution error bit.
// - Any 3xx class error sets the device error bit.
// - Output current/voltage error with questionable bit set sets device error.
// - Any 4xx class error sets the query error bit.
// - Clear status empties the error queue and forces completion idle.
// - Clear status clears event registers and status, keeps enable masks.
// - After the done-clear command, bit 0 sets once pending work finishes.
module sev_status_logic (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Common command strobes
    input  wire logic       maskWrite,
    input  wire logic [7:0] maskData,
    input  wire logic       maskQuery,
    input  wire logic       eventQuery,
    input  wire logic       clearStatus,
    input  wire logic       opDoneCmd,
    // Event sources
    input  wire logic       errValid,
    input  wire logic [2:0] errClass,
    input  wire logic       outputFault,
    input  wire logic       questFault,
    input  wire logic       opsPending,
    // Answers
    output logic      [7:0] readData,
    output logic            readValid,
    output logic      [7:0] eventMask,
    output logic      [7:0] eventLatch,
    output logic            summaryBit,
    output logic            errQueueFlush,
    output logic            otherStatusClear
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic            [7:0] errEvents;
    logic            [7:0] setEvents;
    logic            [7:0] next_latch;
    logic            [7:0] next_mask;
    logic            [7:0] keptLatch;
    logic            [7:0] opClear;
    logic                  opSet;
    sev_pkg::sev_op_e      opState;
    sev_pkg::sev_op_e      next_opState;

    sev_error_class u_class (
        .errValid  (errValid),
        .errClass  (errClass),
        .errEvents (errEvents)
    );

    // Event set terms
    assign opSet = (opState == sev_pkg::OP_WAIT) && !opsPending;
    assign setEvents = (errEvents
        | ({7'h00, (outputFault && questFault)} << sev_pkg::BitDevErr)
        | ({7'h00, opSet} << sev_pkg::BitOpDone)) & sev_pkg::UsedMask;
    // Completion command drops bit 0 so a stale done is not seen as fresh
    assign opClear = {7'h00, opDoneCmd} << sev_pkg::BitOpDone;
    // Set wins over read, clear or completion command; bits otherwise held
    assign keptLatch  = (eventQuery || clearStatus) ? sev_pkg::LatchReset
        : eventLatch;
    assign next_latch = (keptLatch & ~opClear) | setEvents;
    assign next_mask = maskWrite ? maskData : eventMask;

    // ----------------------------------------
    // Completion tracker
    // ----------------------------------------
    // Idle, waiting for pending work, or done; later commands are never held off
    always_comb begin
        next_opState = opState;
        case (opState)
            sev_pkg::OP_IDLE: begin
                // A clear in the same cycle wins, so the tracker stays idle
                if (opDoneCmd && !clearStatus) begin
                    next_opState = sev_pkg::OP_WAIT;
                end
            end
            sev_pkg::OP_WAIT: begin
                if (clearStatus) begin
                    next_opState = sev_pkg::OP_IDLE;
                end else if (!opsPending) begin
                    next_opState = sev_pkg::OP_DONE;
                end
            end
            sev_pkg::OP_DONE: begin
                if (opDoneCmd && !clearStatus) begin
                    next_opState = sev_pkg::OP_WAIT;
                end else if (clearStatus) begin
                    next_opState = sev_pkg::OP_IDLE;
                end
            end
            default: begin
                next_opState = sev_pkg::OP_IDLE;
            end
        endcase
    end

    // State and registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            opState    <= sev_pkg::OP_IDLE;
            eventMask  <= sev_pkg::EnableReset;
            eventLatch <= sev_pkg::LatchReset;
        end else begin
            opState    <= next_opState;
            eventMask  <= next_mask;
            eventLatch <= next_latch;
        end
    end

    // ----------------------------------------
    // Answers
    // ----------------------------------------
    // Query answers and one-cycle status pulses; event query wins the data path
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            readData         <= 8'h00;
            readValid        <= 1'b0;
            summaryBit       <= 1'b0;
            errQueueFlush    <= 1'b0;
            otherStatusClear <= 1'b0;
        end else begin
            readValid        <= maskQuery || eventQuery;
            if (eventQuery) begin
                readData <= eventLatch;
            end else if (maskQuery) begin
                readData <= eventMask;
            end
            summaryBit       <= |(next_latch & next_mask);
            errQueueFlush    <= clearStatus;
            otherStatusClear <= clearStatus;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Mask storage and summary
    mask_reset_a: assert property (@(posedge clock)
        $rose(resetn) |-> eventMask == sev_pkg::EnableReset)
        else $error("mask not zero after reset");
    mask_write_a: assert property (@(posedge clock) disable iff (!resetn)
        maskWrite |=> eventMask == $past(maskData))
        else $error("mask write not stored");
    mask_keep_a: assert property (@(posedge clock) disable iff (!resetn)
        !maskWrite |=> eventMask == $past(eventMask))
        else $error("mask changed without a write");
    summary_or_a: assert property (@(posedge clock) disable iff (!resetn)
        summaryBit == |(eventLatch & eventMask))
        else $error("summary bit mismatch");

    // Query answers
    mask_read_a: assert property (@(posedge clock) disable iff (!resetn)
        maskQuery && !eventQuery |=> readValid && readData == $past(eventMask))
        else $error("mask query wrong");
    event_read_a: assert property (@(posedge clock) disable iff (!resetn)
        eventQuery |=> readValid && readData == $past(eventLatch)
            && eventLatch == $past(setEvents))
        else $error("event read or clear wrong");
    read_idle_a: assert property (@(posedge clock) disable iff (!resetn)
        !maskQuery && !eventQuery |=> !readValid && $stable(readData))
        else $error("answer without a query");

    // Event bit placement and sources
    unused_zero_a: assert property (@(posedge clock) disable iff (!resetn)
        (eventLatch & ~sev_pkg::UsedMask) == 8'h00)
        else $error("unused bit set");
    cmd_err_a: assert property (@(posedge clock) disable iff (!resetn)
        errValid && errClass == sev_pkg::ClassCmd |=> eventLatch[sev_pkg::BitCmdErr])
        else $error("command error not latched");
    exe_err_a: assert property (@(posedge clock) disable iff (!resetn)
        errValid && errClass == sev_pkg::ClassExe |=> eventLatch[sev_pkg::BitExeErr])
        else $error("execution error not latched");
    dev_err_a: assert property (@(posedge clock) disable iff (!resetn)
        errValid && errClass == sev_pkg::ClassDev |=> eventLatch[sev_pkg::BitDevErr])
        else $error("device error not latched");
    dev_fault_a: assert property (@(posedge clock) disable iff (!resetn)
        outputFault && questFault |=> eventLatch[sev_pkg::BitDevErr])
        else $error("output fault not latched");
    qry_err_a: assert property (@(posedge clock) disable iff (!resetn)
        errValid && errClass == sev_pkg::ClassQry |=> eventLatch[sev_pkg::BitQryErr])
        else $error("query error not latched");
    latch_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        !eventQuery && !clearStatus && !opDoneCmd
            |=> (eventLatch & $past(eventLatch)) == $past(eventLatch))
        else $error("event bit lost");

    // Clear status
    clear_keep_a: assert property (@(posedge clock) disable iff (!resetn)
        clearStatus && !maskWrite |=> eventMask == $past(eventMask)
            && errQueueFlush && opState == sev_pkg::OP_IDLE)
        else $error("clear status wrong");
    clear_latch_a: assert property (@(posedge clock) disable iff (!resetn)
        clearStatus |=> eventLatch == $past(setEvents) && otherStatusClear)
        else $error("clear status left events");
    flush_idle_a: assert property (@(posedge clock) disable iff (!resetn)
        !clearStatus |=> !errQueueFlush && !otherStatusClear)
        else $error("status flush without clear");

    // Operation complete tracking
    done_set_a: assert property (@(posedge clock) disable iff (!resetn)
        opState == sev_pkg::OP_WAIT && !opsPending && !clearStatus
            |=> eventLatch[sev_pkg::BitOpDone] && opState == sev_pkg::OP_DONE)
        else $error("completion not flagged");
    op_clear_a: assert property (@(posedge clock) disable iff (!resetn)
        opDoneCmd && !eventQuery && !clearStatus && !opSet
            |=> !eventLatch[sev_pkg::BitOpDone] && opState == sev_pkg::OP_WAIT)
        else $error("completion bit not cleared");
    busy_low_a: assert property (@(posedge clock) disable iff (!resetn)
        opState == sev_pkg::OP_WAIT |-> !eventLatch[sev_pkg::BitOpDone])
        else $error("completion flagged while busy");
endmodule
`default_nettype wire

// file: sev_remote_ctrl.sv
`default_nettype none
// ----------------------------------------
// Remote controller issuing common commands
// ----------------------------------------
module sev_remote_ctrl (
    // Command request
    input  wire logic [2:0] cmdCode,
    input  wire logic [7:0] cmdArg,
    // Common command strobes
    output logic            maskWrite,
    output logic      [7:0] maskData,
    output logic            maskQuery,
    output logic            eventQuery,
    output logic            clearStatus,
    output logic            opDoneCmd
);
    timeunit 1ns;
    timeprecision 1ns;
    // One code gives one strobe, so at most one command is sent per cycle
    assign maskWrite   = (cmdCode == 3'h1);
    assign maskData    = cmdArg;
    assign maskQuery   = (cmdCode == 3'h2);
    assign eventQuery  = (cmdCode == 3'h3);
    assign clearStatus = (cmdCode == 3'h4);
    assign opDoneCmd   = (cmdCode == 3'h5);
endmodule
`default_nettype wire

// file: standard_event_status_logic_bench.sv
`default_nettype none
`define CHECK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module standard_event_status_logic_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Stimulus, answers and reference model
    // ----------------------------------------
    logic clock = 1'b0, resetn = 1'b0, errValid = 1'b0, outputFault = 1'b0, opsPending = 1'b0;
    logic questFault = 1'b0;
    logic [2:0] cmdCode = 3'h0, errClass = 3'h0;
    logic [7:0] cmdArg = 8'h00, maskData, readData, eventMask, eventLatch, mLatch, mMask, mRead;
    logic [7:0] setBits;
    logic maskWrite, maskQuery, eventQuery, clearStatus, opDoneCmd, readValid, summaryBit;
    logic errQueueFlush, otherStatusClear, mValid, mClr;
    sev_pkg::sev_op_e mState;
    int mismatches = 0;
    int n_tests = 0;
    sev_remote_ctrl u_ctrl (.cmdCode(cmdCode), .cmdArg(cmdArg), .maskWrite(maskWrite),
        .maskData(maskData), .maskQuery(maskQuery), .eventQuery(eventQuery),
        .clearStatus(clearStatus), .opDoneCmd(opDoneCmd));
    sev_status_logic u_dut (.clock(clock), .resetn(resetn), .maskWrite(maskWrite),
        .maskData(maskData), .maskQuery(maskQuery), .eventQuery(eventQuery),
        .clearStatus(clearStatus), .opDoneCmd(opDoneCmd), .errValid(errValid),
        .errClass(errClass), .outputFault(outputFault), .questFault(questFault),
        .opsPending(opsPending), .readData(readData), .readValid(readValid),
        .eventMask(eventMask), .eventLatch(eventLatch), .summaryBit(summaryBit),
        .errQueueFlush(errQueueFlush), .otherStatusClear(otherStatusClear));
    // 20 MHz clock
    always #25 clock = ~clock;
    // Event bit raised by one error report
    function automatic logic [7:0] class_bits(input logic v, input logic [2:0] c);
        class_bits = 8'h00;
        if (v && c == sev_pkg::ClassCmd) class_bits[sev_pkg::BitCmdErr] = 1'b1;
        if (v && c == sev_pkg::ClassExe) class_bits[sev_pkg::BitExeErr] = 1'b1;
        if (v && c == sev_pkg::ClassDev) class_bits[sev_pkg::BitDevErr] = 1'b1;
        if (v && c == sev_pkg::ClassQry) class_bits[sev_pkg::BitQryErr] = 1'b1;
    endfunction
    // Reference model, updated on the same edge as the block
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {mLatch, mRead, mValid, mClr} = 18'h00000;
            mMask = sev_pkg::EnableReset;
            mState = sev_pkg::OP_IDLE;
        end else begin
            setBits = class_bits(errValid, errClass);
            if (outputFault && questFault) setBits[sev_pkg::BitDevErr] = 1'b1;
            if (mState == sev_pkg::OP_WAIT && !opsPending) setBits[sev_pkg::BitOpDone] = 1'b1;
            mValid = eventQuery || maskQuery;
            mClr = clearStatus;
            if (eventQuery) mRead = mLatch;
            else if (maskQuery) mRead = mMask;
            if (eventQuery || clearStatus) mLatch = sev_pkg::LatchReset;
            if (opDoneCmd) mLatch[sev_pkg::BitOpDone] = 1'b0;
            mLatch = mLatch | setBits;
            if (maskWrite) mMask = maskData;
            if (clearStatus) mState = sev_pkg::OP_IDLE;
            else if (mState == sev_pkg::OP_WAIT && !opsPending) mState = sev_pkg::OP_DONE;
            else if (opDoneCmd) mState = sev_pkg::OP_WAIT;
        end
    end
    // ----------------------------------------
    // Checks and drive
    // ----------------------------------------
    task automatic check_all();
        `CHECK("eventLatch", mLatch, eventLatch)
        `CHECK("errBits", mLatch[5:2], eventLatch[5:2])
        `CHECK("doneBit", mLatch[0], eventLatch[0])
        `CHECK("eventMask", mMask, eventMask)
        `CHECK("summaryBit", (|(mLatch & mMask)), summaryBit)
        `CHECK("readValid", mValid, readValid)
        `CHECK("readData", mRead, readData)
        `CHECK("errQueueFlush", mClr, errQueueFlush)
        `CHECK("otherStatusClear", mClr, otherStatusClear)
    endtask
    // Check the cycle just done, then drive the next one on the falling edge
    task automatic step(input logic [2:0] code, input logic [7:0] arg, input logic v,
                        input logic [2:0] cls, input logic flt, input logic pend);
        @(negedge clock);
        check_all();
        opsPending = pend;
        cmdCode = code;
        cmdArg = arg;
        errValid = v;
        errClass = cls;
        outputFault = flt;
        questFault = flt | cls[0];
    endtask
    task automatic tally_and_finish();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Corner cases, then random traffic with a second reset in mid-run
    initial begin
        void'($urandom(1));
        repeat (12) @(posedge clock);
        @(negedge clock) resetn = 1'b1;
        step(3'h2, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0);
        step(3'h1, 8'hFF, 1'b0, 3'h0, 1'b0, 1'b0);
        step(3'h2, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0);
        for (int c = 0; c < 8; c++) step(c[0] ? 3'h3 : 3'h0, 8'h00, 1'b1, 3'(c), 1'b0, 1'b0);
        step(3'h0, 8'h00, 1'b0, 3'h0, 1'b1, 1'b0);
        step(3'h1, 8'h00, 1'b0, 3'h0, 1'b0, 1'b1);
        step(3'h5, 8'h00, 1'b0, 3'h0, 1'b0, 1'b1);
        repeat (3) step(3'h3, 8'h00, 1'b0, 3'h0, 1'b0, 1'b1);
        repeat (3) step(3'h0, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0);
        step(3'h5, 8'h00, 1'b0, 3'h0, 1'b0, 1'b1);
        step(3'h1, 8'h3C, 1'b1, 3'h1, 1'b0, 1'b0);
        step(3'h4, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0);
        for (int i = 0; i < 4000; i++) begin
            if (i == 2000) resetn = 1'b0;
            if (i == 2002) resetn = 1'b1;
            step(3'($urandom_range(0, 7)), 8'($urandom), 1'($urandom), 3'($urandom),
                 1'($urandom_range(0, 3) == 0), 1'($urandom));
        end
        step(3'h0, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
